// >>> stp_params.svh
// Purpose: shared constants of the scan test port and its controller
// Assumes: included by bare name from the device, controller and testbench files
// Notes:   instruction codes other than bypass are free to change
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH

// Port and register sizes
`define STP_PORT_W          18
`define STP_IR_W            8
`define STP_CTRL_W          3

// Instruction register
`define STP_IR_CAPTURE      8'h81
`define STP_OP_BYPASS       8'hFF
`define STP_OP_RUN_TEST     8'h09
`define STP_OP_CTRL_SCAN    8'h0A
`define STP_OP_CHAIN_SCAN   8'h02

// Boundary control register opcodes
`define STP_MODE_SIG_RANDOM 3'h3
`define STP_MODE_SIG_COUNT  3'h7
`define STP_CTRL_RESET      3'h0

// Default feedback mask for both 18-bit shift registers
`define STP_TAPS_DEFAULT    18'h20400

// Controller timing: system clocks per half TCK period
`define STP_TCK_HALF        8

// Controller register map
`define STP_REG_CMD         4'h0
`define STP_REG_TX_LO       4'h1
`define STP_REG_TX_HI       4'h2
`define STP_REG_RX_LO       4'h3
`define STP_REG_RX_HI       4'h4
`define STP_REG_STATUS      4'h5
`define STP_CMD_OP_LSB      0
`define STP_CMD_CNT_LSB     8
`define STP_CMDOP_RESET     2'h0
`define STP_CMDOP_IR        2'h1
`define STP_CMDOP_DR        2'h2
`define STP_CMDOP_RUN       2'h3

// TMS sequences, sent lsb first, with their lengths
`define STP_SEQ_RESET       8'h1F
`define STP_SEQ_RESET_LEN   4'h6
`define STP_SEQ_IR          8'h03
`define STP_SEQ_IR_LEN      4'h4
`define STP_SEQ_DR          8'h01
`define STP_SEQ_DR_LEN      4'h3
`define STP_SEQ_POST        8'h01
`define STP_SEQ_POST_LEN    4'h2

`endif

// >>> stp_pkg.sv
// Purpose: types shared by the scan test port and its controller
// Assumes: nothing
// Notes:   state codes left to the tools
package stp_pkg;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} stp_tap_e;

	typedef enum logic [2:0] {
		PH_IDLE, PH_PRE, PH_SHIFT, PH_POST, PH_RUN, PH_DONE
	} stp_phase_e;

endpackage

// >>> stp_link_if.sv
// Purpose: serial test link between controller and device
// Assumes: TDO line is pulled high while nobody drives it
// Notes:   tdo_line is the resolved wire level
`timescale 1ns/100ps
interface stp_link_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe_n;
	logic tdo_line;

	assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

	modport device (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
	modport ctrl (output tck, output tms, output tdi, input tdo_line);
endinterface

// >>> stp_device.sv
// Purpose: test access port with signature and pattern run-test modes
// Assumes: TCK far slower than i_clock; all pins pass a two-flop stage
// Notes:   TCK edges are found by sampling, so they lag the pin by 3 clocks
`timescale 1ns/100ps
`include "stp_params.svh"

module stp_device
	import stp_pkg::*;
#(
	parameter int                      W    = `STP_PORT_W,
	parameter logic [`STP_PORT_W-1:0]  TAPS = `STP_TAPS_DEFAULT
) (
	// Clock and reset
	input  wire logic          i_clock,
	input  wire logic          i_nrst,
	input  wire logic          i_clk_en,
	// Serial test link
	stp_link_if.device         link,
	// Direction controls, active low
	input  wire logic          i_low_ab_en_n,
	input  wire logic          i_high_ab_en_n,
	input  wire logic          i_low_ba_en_n,
	input  wire logic          i_high_ba_en_n,
	// A port pins
	input  wire logic [W-1:0]  i_a_pins,
	output logic      [W-1:0]  o_a_pins,
	output logic      [W-1:0]  o_a_oe_n,
	// B port pins
	input  wire logic [W-1:0]  i_b_pins,
	output logic      [W-1:0]  o_b_pins,
	output logic      [W-1:0]  o_b_oe_n,
	// Status
	output logic               o_run_active
);

	localparam int SYNC_W = 7 + 2 * W;
	localparam int HW     = W / 2;
	localparam int LW     = W - HW;

	logic [SYNC_W-1:0]       s1_q;
	logic [SYNC_W-1:0]       s2_q;
	logic                    tck_s, tms_s, tdi_s;
	logic                    low_ab_s, high_ab_s, low_ba_s, high_ba_s;
	logic [W-1:0]            a_s, b_s;
	logic                    tck_prev_q;
	logic                    rise, fall;
	stp_tap_e                state_q;
	logic [`STP_IR_W-1:0]    ir_sh_q;
	logic [`STP_IR_W-1:0]    instr_q;
	logic [`STP_CTRL_W-1:0]  ctrl_sh_q;
	logic [`STP_CTRL_W-1:0]  ctrl_q;
	logic                    bypass_q;
	logic [W-1:0]            sig_q, pat_q, shadow_q;
	logic                    tdo_q;
	logic                    tdo_oe_n_q;
	logic                    run_q;
	logic                    dir_ab, dir_ba;
	logic                    run_sel, ctrl_sel, chain_sel;
	logic                    run_op;
	logic                    in_shift;
	logic                    shift_out;
	logic [W-1:0]            in_data;

	function automatic stp_tap_e tap_next(input stp_tap_e s, input logic tms);
		case (s)
			TAP_RESET:    tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:     tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:   tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:   tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR:   tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			default:      tap_next = TAP_RESET;
		endcase
	endfunction

	function automatic logic [W-1:0] lfsr_step(input logic [W-1:0] v);
		lfsr_step = {v[W-2:0], ^(v & TAPS)};
	endfunction

	// Every pin and the link pass two flops before use
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_q       <= '0;
			s2_q       <= '0;
			tck_prev_q <= 1'b0;
		end else if (i_clk_en) begin
			s1_q <= {link.tck, link.tms, link.tdi, i_low_ab_en_n, i_high_ab_en_n,
				i_low_ba_en_n, i_high_ba_en_n, i_a_pins, i_b_pins};
			s2_q       <= s1_q;
			tck_prev_q <= tck_s;
		end
	end

	assign {tck_s, tms_s, tdi_s, low_ab_s, high_ab_s, low_ba_s, high_ba_s, a_s, b_s} = s2_q;

	assign rise = i_clk_en & tck_s & ~tck_prev_q;
	assign fall = i_clk_en & ~tck_s & tck_prev_q;

	// Both bytes must agree on one direction
	assign dir_ab    = ~low_ab_s & ~high_ab_s & low_ba_s & high_ba_s;
	assign dir_ba    = low_ab_s & high_ab_s & ~low_ba_s & ~high_ba_s;
	assign run_sel   = (instr_q == `STP_OP_RUN_TEST) && (dir_ab || dir_ba);
	assign ctrl_sel  = (instr_q == `STP_OP_CTRL_SCAN);
	assign chain_sel = (instr_q == `STP_OP_CHAIN_SCAN);
	assign run_op    = run_sel && (state_q == TAP_IDLE) &&
		((ctrl_q == `STP_MODE_SIG_RANDOM) || (ctrl_q == `STP_MODE_SIG_COUNT));
	assign in_shift  = (state_q == TAP_SHIFT_IR) || (state_q == TAP_SHIFT_DR);
	assign in_data   = dir_ab ? a_s : b_s;

	always_comb begin
		if (state_q == TAP_SHIFT_IR) begin
			shift_out = ir_sh_q[0];
		end else if (chain_sel) begin
			shift_out = sig_q[0];
		end else if (ctrl_sel) begin
			shift_out = ctrl_sh_q[0];
		end else begin
			shift_out = bypass_q;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= TAP_RESET;
		end else if (rise) begin
			state_q <= tap_next(state_q, tms_s);
		end
	end

	// Instruction shift stage and active latch
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			ir_sh_q <= `STP_IR_CAPTURE;
		end else if (rise && state_q == TAP_CAP_IR) begin
			ir_sh_q <= `STP_IR_CAPTURE;
		end else if (rise && state_q == TAP_SHIFT_IR) begin
			ir_sh_q <= {tdi_s, ir_sh_q[`STP_IR_W-1:1]};
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			instr_q <= `STP_OP_BYPASS;
		end else if (fall && state_q == TAP_RESET) begin
			instr_q <= `STP_OP_BYPASS;
		end else if (fall && state_q == TAP_UPD_IR) begin
			instr_q <= ir_sh_q;
		end
	end

	// Bypass bit, also used by the run-test instruction
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			bypass_q <= 1'b0;
		end else if (rise && state_q == TAP_CAP_DR) begin
			bypass_q <= 1'b0;
		end else if (rise && state_q == TAP_SHIFT_DR) begin
			bypass_q <= tdi_s;
		end
	end

	// Boundary control register keeps its value at capture
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_sh_q <= `STP_CTRL_RESET;
		end else if (rise && state_q == TAP_SHIFT_DR && ctrl_sel) begin
			ctrl_sh_q <= {tdi_s, ctrl_sh_q[`STP_CTRL_W-1:1]};
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_q <= `STP_CTRL_RESET;
		end else if (fall && state_q == TAP_RESET) begin
			ctrl_q <= `STP_CTRL_RESET;
		end else if (fall && state_q == TAP_UPD_DR && ctrl_sel) begin
			ctrl_q <= ctrl_sh_q;
		end
	end

	// Boundary chain: pattern stages above signature stages, seed scanned in
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			sig_q <= '0;
			pat_q <= '0;
		end else if (rise && state_q == TAP_SHIFT_DR && chain_sel) begin
			{pat_q, sig_q} <= {tdi_s, pat_q, sig_q[W-1:1]};
		end else if (rise && run_op) begin
			sig_q <= lfsr_step(sig_q) ^ in_data;
			if (ctrl_q == `STP_MODE_SIG_COUNT) begin
				pat_q <= pat_q + 1'b1;
			end else begin
				pat_q <= lfsr_step(pat_q);
			end
		end
	end

	// Shadow latches follow the pattern only on falls
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			shadow_q <= '0;
		end else if (fall && (run_op || (state_q == TAP_UPD_DR && chain_sel))) begin
			shadow_q <= pat_q;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			tdo_q      <= 1'b0;
			tdo_oe_n_q <= 1'b1;
		end else if (fall) begin
			tdo_q      <= shift_out;
			tdo_oe_n_q <= ~in_shift;
		end
	end

	// Test mode drives the shadow; otherwise the ports just pass data
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_a_pins <= '0;
			o_b_pins <= '0;
			o_a_oe_n <= '1;
			o_b_oe_n <= '1;
			run_q    <= 1'b0;
		end else if (i_clk_en) begin
			o_a_pins <= run_sel ? shadow_q : b_s;
			o_b_pins <= run_sel ? shadow_q : a_s;
			o_a_oe_n <= {{HW{high_ba_s}}, {LW{low_ba_s}}};
			o_b_oe_n <= {{HW{high_ab_s}}, {LW{low_ab_s}}};
			run_q    <= run_op;
		end
	end

	assign link.tdo      = tdo_q;
	assign link.tdo_oe_n = tdo_oe_n_q;
	assign o_run_active  = run_q;

endmodule // stp_device

// >>> stp_controller.sv
// Purpose: test controller driving the serial link from software commands
// Assumes: commands start from Run-Test/Idle, after a reset command
// Notes:   TCK runs only while a command is busy and rests low
`timescale 1ns/100ps
`include "stp_params.svh"

module stp_controller
	import stp_pkg::*;
#(
	parameter int DATA_W   = 64,
	parameter int CNT_W    = 16,
	parameter int DIV_W    = 8,
	parameter int TCK_HALF = `STP_TCK_HALF
) (
	// Clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_nrst,
	input  wire logic         i_clk_en,
	// Register port
	input  wire logic [3:0]   i_addr,
	input  wire logic [31:0]  i_wdata,
	input  wire logic         i_write,
	input  wire logic         i_read,
	output logic      [31:0]  o_rdata,
	// Status
	output logic              o_busy,
	// Serial test link
	stp_link_if.ctrl          link
);

	localparam int IW = $clog2(DATA_W);

	stp_phase_e           phase_q;
	logic [1:0]           op_q;
	logic [7:0]           seq_q;
	logic [3:0]           seq_cnt_q;
	logic [CNT_W-1:0]     idx_q;
	logic [CNT_W-1:0]     len_q;
	logic [DATA_W-1:0]    tx_q;
	logic [DATA_W-1:0]    rx_q;
	logic [DIV_W-1:0]     div_q;
	logic                 tck_q;
	logic                 tms_q;
	logic                 tdi_q;
	logic                 present_q;
	logic                 tdo_s1_q;
	logic                 tdo_s2_q;
	logic [31:0]          rdata_q;
	logic                 busy;
	logic                 tick;
	logic                 rise_ev;
	logic                 fall_ev;
	logic                 start;
	logic                 last_bit;
	logic                 cur_tms;
	logic [1:0]           wr_op;
	logic [CNT_W-1:0]     wr_cnt;

	assign busy     = (phase_q != PH_IDLE);
	assign tick     = i_clk_en && busy && (div_q == DIV_W'(TCK_HALF - 1));
	assign rise_ev  = tick & ~tck_q;
	assign fall_ev  = tick & tck_q;
	assign start    = i_clk_en && i_write && (i_addr == `STP_REG_CMD) && !busy;
	assign wr_op    = i_wdata[`STP_CMD_OP_LSB +: 2];
	assign wr_cnt   = i_wdata[`STP_CMD_CNT_LSB +: CNT_W];
	assign last_bit = (idx_q == len_q - 1'b1);

	always_comb begin
		case (phase_q)
			PH_PRE:   cur_tms = seq_q[0];
			PH_SHIFT: cur_tms = last_bit;
			PH_POST:  cur_tms = seq_q[0];
			PH_RUN:   cur_tms = 1'b0;
			default:  cur_tms = tms_q;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			div_q <= '0;
			tck_q <= 1'b0;
		end else if (i_clk_en) begin
			div_q <= (tick || !busy) ? '0 : div_q + 1'b1;
			tck_q <= tick ? ~tck_q : tck_q;
		end
	end

	// Link outputs change only after a fall or at command start
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			present_q <= 1'b0;
			tms_q     <= 1'b1;
			tdi_q     <= 1'b0;
		end else if (i_clk_en) begin
			present_q <= start || (fall_ev && phase_q != PH_DONE);
			if (present_q) begin
				tms_q <= cur_tms;
				tdi_q <= (phase_q == PH_SHIFT) ? tx_q[idx_q[IW-1:0]] : 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			tdo_s1_q <= 1'b1;
			tdo_s2_q <= 1'b1;
		end else if (i_clk_en) begin
			tdo_s1_q <= link.tdo_line;
			tdo_s2_q <= tdo_s1_q;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			phase_q   <= PH_IDLE;
			op_q      <= `STP_CMDOP_RESET;
			seq_q     <= '0;
			seq_cnt_q <= '0;
			idx_q     <= '0;
			len_q     <= '0;
		end else if (start) begin
			op_q  <= wr_op;
			idx_q <= '0;
			len_q <= (wr_cnt == '0) ? CNT_W'(1) : wr_cnt;
			case (wr_op)
				`STP_CMDOP_RESET: begin
					phase_q   <= PH_PRE;
					seq_q     <= `STP_SEQ_RESET;
					seq_cnt_q <= `STP_SEQ_RESET_LEN;
				end
				`STP_CMDOP_IR: begin
					phase_q   <= PH_PRE;
					seq_q     <= `STP_SEQ_IR;
					seq_cnt_q <= `STP_SEQ_IR_LEN;
				end
				`STP_CMDOP_DR: begin
					phase_q   <= PH_PRE;
					seq_q     <= `STP_SEQ_DR;
					seq_cnt_q <= `STP_SEQ_DR_LEN;
				end
				default: begin
					phase_q <= PH_RUN;
				end
			endcase
		end else if (rise_ev) begin
			case (phase_q)
				PH_PRE, PH_POST: begin
					seq_q     <= {1'b0, seq_q[7:1]};
					seq_cnt_q <= seq_cnt_q - 1'b1;
					if (seq_cnt_q == 4'h1) begin
						phase_q <= (phase_q == PH_POST || op_q == `STP_CMDOP_RESET) ?
							PH_DONE : PH_SHIFT;
					end
				end
				PH_SHIFT: begin
					if (last_bit) begin
						phase_q   <= PH_POST;
						seq_q     <= `STP_SEQ_POST;
						seq_cnt_q <= `STP_SEQ_POST_LEN;
					end else begin
						idx_q <= idx_q + 1'b1;
					end
				end
				PH_RUN: begin
					if (last_bit) begin
						phase_q <= PH_DONE;
					end else begin
						idx_q <= idx_q + 1'b1;
					end
				end
				default: begin
					phase_q <= phase_q;
				end
			endcase
		end else if (fall_ev && phase_q == PH_DONE) begin
			phase_q <= PH_IDLE;
		end
	end

	// Shifted-out data lands at the bit index it left
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rx_q <= '0;
		end else if (rise_ev && phase_q == PH_SHIFT) begin
			rx_q[idx_q[IW-1:0]] <= tdo_s2_q;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_q <= '0;
		end else if (i_clk_en && i_write && i_addr == `STP_REG_TX_LO) begin
			tx_q[31:0] <= i_wdata;
		end else if (i_clk_en && i_write && i_addr == `STP_REG_TX_HI) begin
			tx_q[DATA_W-1:32] <= i_wdata[DATA_W-33:0];
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_q <= '0;
		end else if (i_clk_en && i_read) begin
			case (i_addr)
				`STP_REG_TX_LO:  rdata_q <= tx_q[31:0];
				`STP_REG_TX_HI:  rdata_q <= tx_q[DATA_W-1:32];
				`STP_REG_RX_LO:  rdata_q <= rx_q[31:0];
				`STP_REG_RX_HI:  rdata_q <= rx_q[DATA_W-1:32];
				`STP_REG_STATUS: rdata_q <= {31'h0, busy};
				default:         rdata_q <= '0;
			endcase
		end
	end

	assign o_rdata  = rdata_q;
	assign o_busy   = busy;
	assign link.tck = tck_q;
	assign link.tms = tms_q;
	assign link.tdi = tdi_q;

endmodule // stp_controller

// >>> stp_link_chk.sv
// Purpose: link checks between controller and device
// Assumes: controller divider left at 8 clocks per TCK half
// Notes:   TAP state is tracked from TMS at each sampled TCK rise
`timescale 1ns/100ps
module stp_link_chk
	import stp_pkg::*;
(
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_nrst,
	// Link signals
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe_n,
	input  wire logic tdo_line
);
	logic       tck_q;
	logic [3:0] fcnt_q;
	logic [7:0] ir_q;
	stp_tap_e   st_q;
	stp_tap_e   st_d;
	wire        rise = tck & ~tck_q;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			tck_q  <= 1'b0;
			fcnt_q <= 4'h0;
		end else begin
			tck_q  <= tck;
			fcnt_q <= (tck_q && !tck) ? 4'h0 : (fcnt_q == 4'hF) ? fcnt_q : fcnt_q + 4'h1;
		end
	end

	always_comb begin
		case (st_q)
			TAP_RESET:    st_d = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:     st_d = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   st_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR, TAP_SHIFT_DR: st_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: st_d = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: st_d = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: st_d = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_SEL_IR:   st_d = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR, TAP_SHIFT_IR: st_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: st_d = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: st_d = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: st_d = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			default:      st_d = tms ? TAP_SEL_DR : TAP_IDLE;
		endcase
	end

	// Shadow of the instruction shifter, to predict TDO bit by bit
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= TAP_RESET;
			ir_q <= 8'h00;
		end else if (rise) begin
			st_q <= st_d;
			if (st_q == TAP_CAP_IR)
				ir_q <= 8'h81;
			else if (st_q == TAP_SHIFT_IR)
				ir_q <= {tdi, ir_q[7:1]};
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	tdo_edge_a: assert property ($changed(tdo) |-> !tck && fcnt_q < 4'h7)
		else $error("tdo moved away from a falling tck");
	oe_edge_a: assert property ($changed(tdo_oe_n) |-> !tck && fcnt_q < 4'h7)
		else $error("tdo enable moved away from a falling tck");
	oe_shift_a: assert property (!tdo_oe_n |-> st_q inside {TAP_SHIFT_IR, TAP_SHIFT_DR,
		TAP_EXIT1_IR, TAP_EXIT1_DR}) else $error("tdo driven outside shift");
	oe_on_a: assert property ($fell(tck) && st_q inside {TAP_SHIFT_IR, TAP_SHIFT_DR}
		|-> ##[1:6] !tdo_oe_n) else $error("tdo not enabled in shift");
	oe_off_a: assert property ($fell(tck) && st_q inside {TAP_EXIT1_IR, TAP_EXIT1_DR}
		|-> ##[1:6] tdo_oe_n) else $error("tdo not released in exit");
	ir_out_a: assert property (rise && st_q == TAP_SHIFT_IR |-> tdo_line == ir_q[0])
		else $error("instruction shifter bit wrong on tdo");
	tms_edge_a: assert property ($changed(tms) |-> !tck)
		else $error("tms moved while tck high");
	tdi_edge_a: assert property ($changed(tdi) |-> !tck)
		else $error("tdi moved while tck high");
	tck_half_a: assert property ($rose(tck) |-> tck [*8] ##1 !tck)
		else $error("tck high phase not 8 clocks");
endmodule // stp_link_chk

// >>> scan_test_signature_pattern_logic_tb.sv
// Purpose: controller and device back to back, checked against a model
// Assumes: default controller divider and feedback mask
// Notes:   input pins stay still during a run so each rise folds one value
`timescale 1ns/100ps
`include "stp_params.svh"
module scan_test_signature_pattern_logic_tb;
	localparam logic [17:0] TAPS = `STP_TAPS_DEFAULT;
	logic        i_clock = 1'b0;
	logic        i_nrst  = 1'b0;
	logic [3:0]  i_addr  = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic        i_write = 1'b0;
	logic        i_read  = 1'b0;
	logic [3:0]  en_n    = 4'hC;
	logic [17:0] a_in    = 18'h0;
	logic [17:0] b_in    = 18'h0;
	logic        clk_en  = 1'b1;
	wire  [31:0] o_rdata;
	wire  [17:0] a_out, b_out, a_oe, b_oe;
	wire         run_act;
	wire         busy;
	int          errors = 0, n_checks = 0, cycles = 0;

	stp_link_if link();
	stp_device stp_device_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(clk_en), .link(link),
		.i_low_ab_en_n(en_n[0]), .i_high_ab_en_n(en_n[1]), .i_low_ba_en_n(en_n[2]),
		.i_high_ba_en_n(en_n[3]), .i_a_pins(a_in), .o_a_pins(a_out), .o_a_oe_n(a_oe),
		.i_b_pins(b_in), .o_b_pins(b_out), .o_b_oe_n(b_oe), .o_run_active(run_act));
	stp_controller stp_controller_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(clk_en),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
		.o_rdata(o_rdata), .o_busy(busy), .link(link));
	stp_link_chk stp_link_chk_inst (.i_clock(i_clock), .i_nrst(i_nrst), .tck(link.tck),
		.tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe_n(link.tdo_oe_n),
		.tdo_line(link.tdo_line));

	initial forever #2.5 i_clock = ~i_clock;

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
			errors++;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_addr  <= a;
		i_wdata <= d;
		i_write <= 1'b1;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_read <= 1'b1;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1 d = o_rdata;
	endtask

	// Busy is polled over the register port, bounded
	task automatic cmd(input logic [1:0] op, input int n, input logic [63:0] tx,
		output logic [63:0] rx);
		logic [31:0] d;
		int          k;
		wr(`STP_REG_TX_LO, tx[31:0]);
		wr(`STP_REG_TX_HI, tx[63:32]);
		wr(`STP_REG_CMD, {8'h00, n[15:0], 6'h00, op});
		@(negedge i_clock);
		chk(busy, 1'b1);
		d = 32'h1;
		for (k = 0; k < 3000 && d[0] === 1'b1; k++)
			rd(`STP_REG_STATUS, d);
		chk(d, 32'h0);
		chk(busy, 1'b0);
		rd(`STP_REG_RX_LO, rx[31:0]);
		rd(`STP_REG_RX_HI, rx[63:32]);
	endtask

	task automatic ir(input logic [7:0] code);
		logic [63:0] rx;
		cmd(`STP_CMDOP_IR, 8, {56'h0, code}, rx);
		chk(rx[7:0], 8'h81);
	endtask

	initial begin
		logic [63:0] rx, tx;
		logic [17:0] sig, pat, shd, inp;
		logic [2:0]  mode, ctrl_m;
		int          n, p, k;
		void'($urandom(11182));
		repeat (8) @(posedge i_clock);
		i_nrst <= 1'b1;
		a_in   <= $urandom;
		b_in   <= $urandom;
		repeat (8) @(posedge i_clock);
		chk(b_out, a_in);
		chk(a_out, b_in);
		// Clock enable low must hold the B pin output
		inp = a_in;
		clk_en <= 1'b0;
		a_in   <= ~a_in;
		repeat (8) @(posedge i_clock);
		chk(b_out, inp);
		clk_en <= 1'b1;
		repeat (8) @(posedge i_clock);
		chk(b_out, a_in);
		tx = {$urandom, $urandom};
		wr(`STP_REG_TX_LO, tx[31:0]);
		rd(`STP_REG_TX_LO, rx[31:0]);
		chk(rx[31:0], tx[31:0]);
		rd(4'hF, rx[31:0]);
		chk(rx[31:0], 32'h0);
		cmd(`STP_CMDOP_RESET, 1, 64'h0, rx);
		ir(`STP_OP_BYPASS);
		cmd(`STP_CMDOP_DR, 8, tx, rx);
		chk(rx[7:0], {tx[6:0], 1'b0});
		sig = 18'h0;
		pat = 18'h0;
		ctrl_m = 3'h0;
		// Passes: random A to B, count B to A, zero seed, mixed directions
		for (p = 0; p < 4; p++) begin
			mode = (p == 1) ? `STP_MODE_SIG_COUNT : `STP_MODE_SIG_RANDOM;
			ir(`STP_OP_CTRL_SCAN);
			tx = {$urandom, $urandom};
			inp = (p == 1) ? tx[49:32] : tx[17:0];
			@(posedge i_clock);
			a_in <= tx[17:0];
			b_in <= tx[49:32];
			en_n <= (p == 1) ? 4'h3 : (p == 3) ? 4'h6 : 4'hC;
			cmd(`STP_CMDOP_DR, 3, {61'h0, mode}, rx);
			chk(rx[2:0], ctrl_m);
			ctrl_m = mode;
			ir(`STP_OP_CHAIN_SCAN);
			tx = {$urandom, $urandom};
			if (p == 2)
				tx[35:18] = 18'h0;
			cmd(`STP_CMDOP_DR, 36, tx, rx);
			chk(rx[35:0], {pat, sig});
			{pat, sig} = tx[35:0];
			ir(`STP_OP_RUN_TEST);
			n = 4 + $urandom % 16;
			cmd(`STP_CMDOP_RUN, n, 64'h0, rx);
			repeat (6) @(posedge i_clock);
			// The next command's first rise still falls in the run state
			for (k = 0; k <= n && p != 3; k++) begin
				if (k == n)
					shd = pat;
				sig = {sig[16:0], ^(sig & TAPS)} ^ inp;
				pat = (mode == 3'h7) ? pat + 18'h1 : {pat[16:0], ^(pat & TAPS)};
			end
			chk(run_act, p != 3);
			chk((p == 1) ? a_out : b_out, (p == 3) ? inp : shd);
			chk((p == 1) ? a_oe : b_oe, (p == 3) ? 18'h3FE00 : 18'h0);
		end
		ir(`STP_OP_CHAIN_SCAN);
		cmd(`STP_CMDOP_DR, 36, 64'h0, rx);
		chk(rx[35:0], {pat, sig});
		tally_and_finish();
	end
endmodule // scan_test_signature_pattern_logic_tb
